//--- dv/tb_top.sv
// Self-checking bench for the endpoint mask bank
`timescale 1ns/1ps
`define chk(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("mismatch at %0t: got %h want %h", $time, (a), (e)); end end
module tb_top;
	logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0]   haddr, hwdata, hrdata, v, r;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [159:0]  oflags;
	logic [15:0]   inpend, txe;
	logic          spulse, sdisch, np_en, p_en, rx_en;
	logic [8:0]    tx_len, rx_len;
	int            err_total, tests_run, e, n;
	logic [11:0]   offs [7] = '{uem_pkg::OFF_OUT_SRC_MASK, uem_pkg::OFF_PEND_SUMMARY,
		uem_pkg::OFF_SUMMARY_MASK, uem_pkg::OFF_DISCHARGE_TIME, uem_pkg::OFF_PULSE_TIME,
		uem_pkg::OFF_THRESH_CTRL, uem_pkg::OFF_TX_EMPTY_MASK};
	logic [31:0]   rstv [7] = '{0, 0, 0, uem_pkg::DISCHARGE_RESET, uem_pkg::PULSE_RESET, 0, 0};
	logic [31:0]   vmsk [7] = '{uem_pkg::OUT_SRC_VALID, 0, 32'hffff_ffff, 32'h0000_ffff,
		32'h0000_0fff, uem_pkg::THRESH_VALID, 32'h0000_ffff};
	int            srcs [7] = '{0, 1, 3, 4, 6, 8, 9};
	uem_ep_int_mask_regs #(.NUM_EP(16), .PHY_DIV(1)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .out_ep_src_flags(oflags), .in_ep_pending(inpend),
		.tx_empty_flag(txe), .supply_pulse(spulse), .supply_discharge(sdisch),
		.nonperiodic_tx_thresh_en(np_en), .periodic_tx_thresh_en(p_en),
		.tx_thresh_length(tx_len), .rx_thresh_en(rx_en), .rx_thresh_length(rx_len), .irq(irq));
	uem_host_model #(.NUM_EP(16)) host (.hclk(hclk), .out_ep_src_flags(oflags),
		.in_ep_pending(inpend), .tx_empty_flag(txe));
	always #2 hclk = ~hclk;
	function automatic logic [8:0] tlen(input logic [8:0] w);
		return (w < uem_pkg::THRESH_MIN_WORDS) ? uem_pkg::THRESH_MIN_WORDS : w;
	endfunction
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		`chk(r, x)
		`chk(hresp, 1'b0)
	endtask
	task automatic pause(input int c);
		repeat (c) @(posedge hclk);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		pause(20000);
		err_total++;
		results();
	end
	initial begin
		{hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
		hsize = 3'b010;
		void'($urandom(32'h228a));
		pause(20);
		hresetn <= 1'b1;
		foreach (offs[i]) rc(offs[i], rstv[i]);
		rc(12'h824, 32'h0);
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0011_001f : $urandom;
			foreach (offs[i]) begin
				wr(offs[i], v);
				rc(offs[i], v & vmsk[i]);
			end
			`chk({np_en, p_en, rx_en}, {v[0], v[1], v[16]})
			`chk(tx_len, tlen(v[10:2]))
			`chk(rx_len, tlen(v[25:17]))
		end
		$display("test registers done");
		e = $urandom_range(15, 0);
		wr(uem_pkg::OFF_IRQ_MASK, 32'h3);
		wr(uem_pkg::OFF_TX_EMPTY_MASK, 32'h0);
		wr(uem_pkg::OFF_SUMMARY_MASK, 32'h0);
		wr(uem_pkg::OFF_OUT_SRC_MASK, uem_pkg::OUT_SRC_VALID);
		host.set_out(e, 0, 1'b1, 1);
		pause(5);
		`chk(irq, 1'b0)
		host.set_out(e, 0, 1'b0, 0);
		wr(uem_pkg::OFF_SUMMARY_MASK, 32'h1 << (e + 16));
		foreach (srcs[j]) begin
			wr(uem_pkg::OFF_OUT_SRC_MASK, uem_pkg::OUT_SRC_VALID & ~(32'h1 << srcs[j]));
			host.set_out(e, srcs[j], 1'b1, j % 3);
			pause(5);
			`chk(irq, 1'b0)
			wr(uem_pkg::OFF_OUT_SRC_MASK, 32'h1 << srcs[j]);
			pause(5);
			`chk(irq, 1'b1)
			rc(uem_pkg::OFF_PEND_SUMMARY, 32'h1 << (e + 16));
			host.set_out(e, srcs[j], 1'b0, 0);
			wr(uem_pkg::OFF_IRQ_STATUS, 32'h2);
			pause(2);
			`chk(irq, 1'b0)
		end
		$display("test out sources done");
		wr(uem_pkg::OFF_SUMMARY_MASK, 32'h0);
		host.set_in(e, 1'b1, 1'b0, 2);
		pause(5);
		`chk(irq, 1'b0)
		rc(uem_pkg::OFF_PEND_SUMMARY, 32'h1 << e);
		wr(uem_pkg::OFF_SUMMARY_MASK, 32'h1 << e);
		pause(5);
		`chk(irq, 1'b1)
		wr(uem_pkg::OFF_IRQ_MASK, 32'h0);
		pause(2);
		`chk(irq, 1'b0)
		host.set_in(e, 1'b0, 1'b1, 0);
		wr(uem_pkg::OFF_IRQ_STATUS, 32'h1);
		wr(uem_pkg::OFF_IRQ_MASK, 32'h3);
		pause(5);
		`chk(irq, 1'b0)
		wr(uem_pkg::OFF_TX_EMPTY_MASK, 32'h1 << e);
		pause(5);
		`chk(irq, 1'b1)
		host.set_in(e, 1'b0, 1'b0, 0);
		wr(uem_pkg::OFF_IRQ_STATUS, 32'h1);
		$display("test in endpoints done");
		wr(uem_pkg::OFF_PULSE_TIME, 32'h1);
		wr(uem_pkg::OFF_DISCHARGE_TIME, 32'h1);
		wr(uem_pkg::OFF_IRQ_MASK, 32'h4);
		wr(uem_pkg::OFF_SRP_CTRL, 32'h1);
		for (n = 0; spulse !== 1'b1 && n < 10; n++) @(posedge hclk);
		for (n = 0; spulse === 1'b1; n++) @(posedge hclk);
		`chk(n, uem_pkg::PHY_CLKS_PER_UNIT)
		for (n = 0; sdisch === 1'b1; n++) @(posedge hclk);
		`chk(n, uem_pkg::PHY_CLKS_PER_UNIT)
		pause(5);
		`chk(irq, 1'b1)
		$display("test supply sequence done");
		results();
	end
endmodule

//--- dv/uem_host_model.sv
// Host-side model: endpoint event levels driven toward the mask bank
`timescale 1ns/1ps
module uem_host_model #(
	parameter int NUM_EP = 16
) (
	hclk,
	out_ep_src_flags,
	in_ep_pending,
	tx_empty_flag
);
	input  wire logic             hclk;
	output logic [NUM_EP*10-1:0]  out_ep_src_flags;
	output logic [NUM_EP-1:0]     in_ep_pending;
	output logic [NUM_EP-1:0]     tx_empty_flag;
	initial begin
		out_ep_src_flags = '0;
		in_ep_pending = '0;
		tx_empty_flag = '0;
	end
	// One OUT source level, after lag + 1 edges
	task automatic set_out(input int ep, input int src, input logic v, input int lag);
		repeat (lag + 1) @(posedge hclk);
		out_ep_src_flags[ep*10+src] <= v;
	endtask
	// IN pending and tx-empty levels, after lag + 1 edges
	task automatic set_in(input int ep, input logic pend, input logic empty, input int lag);
		repeat (lag + 1) @(posedge hclk);
		in_ep_pending[ep] <= pend;
		tx_empty_flag[ep] <= empty;
	endtask
endmodule

//--- hw/uem_ep_int_mask_regs.sv
// Endpoint interrupt mask, summary, supply timing and threshold register bank on AHB-Lite
// Summary of operation
// - OUT mask bit 0 gates transfer-complete, bit 1 endpoint-disabled; 1 passes
// - OUT mask bit 3 gates setup-done, bit 4 token-while-off; bits 2,5,7 reserved
// - OUT mask bits 6,8,9 gate setup, packet error, buffer; 31:10 reserved
// - Summary bits 15:0 show pending interrupt of IN endpoint X
// - Summary bits 31:16 show pending interrupt of OUT endpoint X-16
// - Summary bits track each endpoint's own interrupt register state
// - Summary mask bits 15:0 pass IN endpoint interrupts when 1
// - Summary mask bits 31:16 pass OUT endpoint interrupts when 1
// - Discharge field, 16 bits, units of 1024 PHY clocks, resets to default
// - Pulse field, 12 bits, sets supply pulse length in 1024 PHY clocks
// - Threshold bit 0 enables non-isochronous, bit 1 isochronous transmit thresholding
// - Transmit threshold length in bits 10:2, words, at least 8
// - Receive threshold enable bit 16, length bits 25:17, at least 8
// - Tx-empty mask bit X gates FIFO-empty flag of IN endpoint X
`timescale 1ns/1ps
module uem_ep_int_mask_regs #(
	parameter int NUM_EP  = 16,
	parameter int PHY_DIV = 4
) (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	input  wire logic [NUM_EP*10-1:0]     out_ep_src_flags,
	input  wire logic [NUM_EP-1:0]        in_ep_pending,
	input  wire logic [NUM_EP-1:0]        tx_empty_flag,
	output logic                          supply_pulse,
	output logic                          supply_discharge,
	output logic                          nonperiodic_tx_thresh_en,
	output logic                          periodic_tx_thresh_en,
	output logic [8:0]                    tx_thresh_length,
	output logic                          rx_thresh_en,
	output logic [8:0]                    rx_thresh_length,
	output logic                          irq
);
	initial begin
		if (NUM_EP < 1 || NUM_EP > 16)
			$error("NUM_EP must be 1 to 16");
		if (PHY_DIV < 1 || PHY_DIV > 256)
			$error("PHY_DIV must be 1 to 256");
	end

	typedef struct packed {
		logic                 wr_pend;
		logic [11:0]          wr_addr;
		logic [31:0]          rdata;
		logic [31:0]          out_src_mask;
		logic [31:0]          summary;
		logic [31:0]          summary_mask;
		logic [15:0]          discharge;
		logic [11:0]          pulse;
		logic [31:0]          thresh;
		logic [15:0]          tx_empty_mask;
		logic [2:0]           irq_stat;
		logic [2:0]           irq_mask;
		logic [2:0]           prev_hit;
		uem_pkg::uem_srp_type srp;
		logic [7:0]           phy_div;
		logic [9:0]           pre;
		logic [15:0]          units;
	} uem_state_type;

	uem_state_type s;
	uem_state_type n;

	logic [15:0] in_hit;
	logic [15:0] out_hit;
	logic        acc;
	logic        srp_done;
	logic        unit_tick;

	function automatic logic [8:0] eff_len(input logic [8:0] v);
		eff_len = (v < uem_pkg::THRESH_MIN_WORDS) ? uem_pkg::THRESH_MIN_WORDS : v;
	endfunction

	function automatic logic [31:0] read_word(input logic [11:0] a, input uem_state_type r);
		case (a)
			uem_pkg::OFF_OUT_SRC_MASK:   read_word = r.out_src_mask;
			uem_pkg::OFF_PEND_SUMMARY:   read_word = r.summary;
			uem_pkg::OFF_SUMMARY_MASK:   read_word = r.summary_mask;
			uem_pkg::OFF_DISCHARGE_TIME: read_word = {16'h0000, r.discharge};
			uem_pkg::OFF_PULSE_TIME:     read_word = {20'h00000, r.pulse};
			uem_pkg::OFF_THRESH_CTRL:    read_word = r.thresh;
			uem_pkg::OFF_TX_EMPTY_MASK:  read_word = {16'h0000, r.tx_empty_mask};
			uem_pkg::OFF_IRQ_STATUS:     read_word = {29'h0000000, r.irq_stat};
			uem_pkg::OFF_IRQ_MASK:       read_word = {29'h0000000, r.irq_mask};
			uem_pkg::OFF_SRP_CTRL:       read_word = {31'h00000000, r.srp != uem_pkg::SRP_IDLE};
			default:                     read_word = 32'h0000_0000;
		endcase
	endfunction

	assign acc = hsel && htrans[1] && hready;

	always_comb begin
		n = s;
		srp_done = 1'b0;
		unit_tick = 1'b0;
		in_hit = 16'h0000;
		out_hit = 16'h0000;
		n.summary = 32'h0000_0000;
		for (int e = 0; e < NUM_EP; e++) begin
			// IN summary and gating, including tx-empty flag
			n.summary[uem_pkg::IN_SUM_LSB + e] = in_ep_pending[e] | tx_empty_flag[e];
			in_hit[e] = s.summary_mask[uem_pkg::IN_SUM_LSB + e]
				& (in_ep_pending[e] | (tx_empty_flag[e] & s.tx_empty_mask[e]));
			// OUT summary tracks the raw register, gating needs both masks
			n.summary[uem_pkg::OUT_SUM_LSB + e] =
				|(out_ep_src_flags[e*10 +: 10] & uem_pkg::OUT_SRC_VALID[9:0]);
			out_hit[e] = s.summary_mask[uem_pkg::OUT_SUM_LSB + e]
				& |(out_ep_src_flags[e*10 +: 10] & s.out_src_mask[9:0]);
		end

		// Supply pulse then discharge, counted in 1024 PHY clock units
		n.phy_div = (s.phy_div == 8'(PHY_DIV - 1)) ? 8'h00 : s.phy_div + 8'h01;
		if (s.phy_div == 8'(PHY_DIV - 1)) begin
			n.pre = s.pre + 10'h001;
			unit_tick = (s.pre == 10'(uem_pkg::PHY_CLKS_PER_UNIT - 1));
		end
		if (unit_tick)
			n.units = s.units + 16'h0001;
		case (s.srp)
			uem_pkg::SRP_IDLE: begin
				n.pre = 10'h000;
				n.units = 16'h0000;
			end
			uem_pkg::SRP_PULSE: begin
				if (unit_tick && (s.units + 16'h0001) == {4'h0, s.pulse}) begin
					n.units = 16'h0000;
					if (s.discharge == 16'h0000) begin
						n.srp = uem_pkg::SRP_IDLE;
						srp_done = 1'b1;
					end else begin
						n.srp = uem_pkg::SRP_DISCH;
					end
				end
			end
			uem_pkg::SRP_DISCH: begin
				if (unit_tick && (s.units + 16'h0001) == s.discharge) begin
					n.srp = uem_pkg::SRP_IDLE;
					srp_done = 1'b1;
				end
			end
			default: begin
				n.srp = uem_pkg::SRP_IDLE;
			end
		endcase

		// Sticky events, a set beats a write-one clear in the same cycle
		n.prev_hit = {srp_done, |out_hit, |in_hit};
		if (s.wr_pend && s.wr_addr == uem_pkg::OFF_IRQ_STATUS)
			n.irq_stat = s.irq_stat & ~hwdata[2:0];
		n.irq_stat = n.irq_stat | (n.prev_hit & ~s.prev_hit);

		// Data phase of a write
		if (s.wr_pend) begin
			case (s.wr_addr)
				uem_pkg::OFF_OUT_SRC_MASK:   n.out_src_mask = hwdata & uem_pkg::OUT_SRC_VALID;
				uem_pkg::OFF_SUMMARY_MASK:   n.summary_mask = hwdata;
				uem_pkg::OFF_DISCHARGE_TIME: n.discharge = hwdata[15:0];
				uem_pkg::OFF_PULSE_TIME:     n.pulse = hwdata[11:0];
				uem_pkg::OFF_THRESH_CTRL:    n.thresh = hwdata & uem_pkg::THRESH_VALID;
				uem_pkg::OFF_TX_EMPTY_MASK:  n.tx_empty_mask = hwdata[15:0];
				uem_pkg::OFF_IRQ_MASK:       n.irq_mask = hwdata[2:0];
				uem_pkg::OFF_SRP_CTRL: begin
					if (hwdata[uem_pkg::SRP_START_BIT] && s.srp == uem_pkg::SRP_IDLE) begin
						n.phy_div = 8'h00;
						n.pre = 10'h000;
						n.units = 16'h0000;
						if (s.pulse != 12'h000)
							n.srp = uem_pkg::SRP_PULSE;
						else if (s.discharge != 16'h0000)
							n.srp = uem_pkg::SRP_DISCH;
					end
				end
				default: begin
				end
			endcase
		end

		// Address phase; read data taken after any write in progress
		n.wr_pend = acc && hwrite;
		if (acc)
			n.wr_addr = haddr[11:0];
		if (acc && !hwrite)
			n.rdata = read_word(haddr[11:0], n);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s.wr_pend       <= 1'b0;
			s.wr_addr       <= 12'h000;
			s.rdata         <= 32'h0000_0000;
			s.out_src_mask  <= 32'h0000_0000;
			s.summary       <= 32'h0000_0000;
			s.summary_mask  <= 32'h0000_0000;
			s.discharge     <= uem_pkg::DISCHARGE_RESET[15:0];
			s.pulse         <= uem_pkg::PULSE_RESET[11:0];
			s.thresh        <= 32'h0000_0000;
			s.tx_empty_mask <= 16'h0000;
			s.irq_stat      <= 3'h0;
			s.irq_mask      <= 3'h0;
			s.prev_hit      <= 3'h0;
			s.srp           <= uem_pkg::SRP_IDLE;
			s.phy_div       <= 8'h00;
			s.pre           <= 10'h000;
			s.units         <= 16'h0000;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s.rdata;
	assign irq       = |(s.irq_stat & s.irq_mask);
	assign supply_pulse     = s.srp[1];
	assign supply_discharge = s.srp[2];
	// Threshold controls, lengths never below 8 words
	assign nonperiodic_tx_thresh_en = s.thresh[uem_pkg::NONPERIODIC_TX_THRESH_EN_BIT];
	assign periodic_tx_thresh_en    = s.thresh[uem_pkg::PERIODIC_TX_THRESH_EN_BIT];
	assign tx_thresh_length = eff_len(s.thresh[uem_pkg::TX_THRESH_LENGTH_LSB +: 9]);
	assign rx_thresh_en     = s.thresh[uem_pkg::RX_THRESH_EN_BIT];
	assign rx_thresh_length = eff_len(s.thresh[uem_pkg::RX_THRESH_LENGTH_LSB +: 9]);

	// Checking helpers
	logic        dis_written;
	logic [31:0] pulse_cycles;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dis_written  <= 1'b0;
			pulse_cycles <= 32'h0000_0000;
		end else begin
			if (s.wr_pend && s.wr_addr == uem_pkg::OFF_DISCHARGE_TIME)
				dis_written <= 1'b1;
			pulse_cycles <= supply_pulse ? pulse_cycles + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence wr_to(logic [11:0] off);
		(acc && hwrite && haddr[11:0] == off) ##1 1'b1;
	endsequence

	AST_OUT_MASK_WRITE: assert property (wr_to(uem_pkg::OFF_OUT_SRC_MASK) |=>
		s.out_src_mask == ($past(hwdata) & uem_pkg::OUT_SRC_VALID))
		else $error("OUT source mask not stored with reserved bits cleared");
	AST_OUT_RESERVED: assert property ((s.out_src_mask & ~uem_pkg::OUT_SRC_VALID) == 32'h0
		&& s.out_src_mask[31:10] == 22'h0)
		else $error("OUT source mask reserved bits set");
	AST_OUT_GATE: assert property ($rose(s.irq_stat[uem_pkg::IRQ_OUT_EVENT_BIT]) |->
		$past(|out_hit, 1) && $past(s.out_src_mask[9:0] != 10'h000, 1))
		else $error("OUT event raised with all sources masked");
	AST_IN_SUMMARY: assert property (##1 s.summary[15:0] ==
		16'($past(in_ep_pending | tx_empty_flag)))
		else $error("IN summary does not follow endpoint state");
	AST_OUT_SUMMARY: assert property ((|out_ep_src_flags) ##1 1'b1 |->
		s.summary[31:16] != 16'h0000 || $past(out_ep_src_flags & {NUM_EP{10'h35b}}) == '0)
		else $error("OUT summary misses a pending endpoint");
	AST_SUMMARY_TRACK: assert property ((in_ep_pending == '0 && tx_empty_flag == '0
		&& out_ep_src_flags == '0) |=> s.summary == 32'h0000_0000)
		else $error("Summary shows an endpoint with nothing pending");
	AST_IN_GATE: assert property ($rose(s.irq_stat[uem_pkg::IRQ_IN_EVENT_BIT]) |->
		$past(s.summary_mask[15:0] != 16'h0000, 1))
		else $error("IN event passed with all summary masks clear");
	AST_OUT_SUMMASK: assert property (s.summary_mask[31:16] == 16'h0000 |-> out_hit == 16'h0)
		else $error("OUT event passed with summary mask clear");
	AST_DIS_RESET: assert property (!dis_written |-> s.discharge == 16'h17d7)
		else $error("Discharge time left its reset value unwritten");
	AST_PULSE_LEN: assert property ($fell(supply_pulse) |->
		$past(pulse_cycles) + 32'h1 == {20'h0, s.pulse} * 32'(uem_pkg::PHY_CLKS_PER_UNIT * PHY_DIV))
		else $error("Supply pulse length wrong");
	AST_THRESH_EN: assert property (wr_to(uem_pkg::OFF_THRESH_CTRL) |=>
		nonperiodic_tx_thresh_en == $past(hwdata[0]) && periodic_tx_thresh_en == $past(hwdata[1]))
		else $error("Transmit threshold enables not taken");
	AST_TX_MIN: assert property (tx_thresh_length >= 9'h008)
		else $error("Transmit threshold below eight words");
	AST_RX_MIN: assert property (rx_thresh_length >= 9'h008)
		else $error("Receive threshold below eight words");
	AST_TXE_GATE: assert property ((s.tx_empty_mask == 16'h0 && in_ep_pending == '0)
		|-> in_hit == 16'h0)
		else $error("Tx-empty flag passed while masked");
	AST_IRQ_LEVEL: assert property (irq |-> $past(|n.prev_hit) || $past(irq)
		|| $past(s.wr_pend && s.wr_addr == uem_pkg::OFF_IRQ_MASK))
		else $error("Interrupt raised without a gated event");
endmodule

//--- hw/uem_pkg.sv
// Package with offsets, field layouts, reset values and states of the endpoint mask bank
package uem_pkg;
	localparam logic [11:0] OFF_OUT_SRC_MASK   = 12'h814;
	localparam logic [11:0] OFF_PEND_SUMMARY   = 12'h818;
	localparam logic [11:0] OFF_SUMMARY_MASK   = 12'h81c;
	localparam logic [11:0] OFF_DISCHARGE_TIME = 12'h828;
	localparam logic [11:0] OFF_PULSE_TIME     = 12'h82c;
	localparam logic [11:0] OFF_THRESH_CTRL    = 12'h830;
	localparam logic [11:0] OFF_TX_EMPTY_MASK  = 12'h834;
	localparam logic [11:0] OFF_IRQ_STATUS     = 12'h8f0;
	localparam logic [11:0] OFF_IRQ_MASK       = 12'h8f4;
	localparam logic [11:0] OFF_SRP_CTRL       = 12'h8f8;

	localparam int XFER_DONE_MASK_BIT          = 0;
	localparam int EP_DISABLED_MASK_BIT        = 1;
	localparam int SETUP_DONE_MASK_BIT         = 3;
	localparam int TOKEN_WHILE_OFF_MASK_BIT    = 4;
	localparam int BACK_TO_BACK_SETUP_MASK_BIT = 6;
	localparam int OUT_PACKET_ERROR_MASK_BIT   = 8;
	localparam int BUFFER_UNAVAILABLE_MASK_BIT = 9;
	localparam int OUT_SRC_BITS                = 10;
	localparam logic [31:0] OUT_SRC_VALID      = 32'h0000_035b;

	localparam int IN_SUM_LSB  = 0;
	localparam int OUT_SUM_LSB = 16;
	localparam int SUM_WIDTH   = 16;

	localparam logic [31:0] DISCHARGE_RESET = 32'h0000_17d7;
	localparam logic [31:0] PULSE_RESET     = 32'h0000_0000;
	localparam int DISCHARGE_WIDTH          = 16;
	localparam int PULSE_WIDTH              = 12;
	localparam int PHY_CLKS_PER_UNIT        = 1024;

	localparam int NONPERIODIC_TX_THRESH_EN_BIT = 0;
	localparam int PERIODIC_TX_THRESH_EN_BIT    = 1;
	localparam int TX_THRESH_LENGTH_LSB         = 2;
	localparam int RX_THRESH_EN_BIT             = 16;
	localparam int RX_THRESH_LENGTH_LSB         = 17;
	localparam int THRESH_LENGTH_WIDTH          = 9;
	localparam logic [8:0] THRESH_MIN_WORDS     = 9'h008;
	localparam logic [31:0] THRESH_VALID        = 32'h03ff_07ff;

	localparam int IRQ_IN_EVENT_BIT  = 0;
	localparam int IRQ_OUT_EVENT_BIT = 1;
	localparam int IRQ_SRP_DONE_BIT  = 2;
	localparam int IRQ_BITS          = 3;
	localparam int SRP_START_BIT     = 0;

	typedef enum logic [2:0] {
		SRP_IDLE  = 3'b001,
		SRP_PULSE = 3'b010,
		SRP_DISCH = 3'b100
	} uem_srp_type;
endpackage
